//--- core/hvf_defines.svh
// Constants for the HD video sample formatter: levels, line and picture geometry.
// Assumes a single inclusion per compilation unit; the guard covers repeats.
// Functional notes
// RULE1 - Depth factor one for 8-bit, four for 10-bit.
// RULE2 - RGB/luma code: in*219D plus 16D, rounded.
// RULE3 - Chroma code: in*224D plus 128D, rounded.
// RULE4 - One-way link, single source, single destination.
// RULE5 - Video and timing words 8 or 10 bits.
// RULE6 - Luma plus chroma sent as 20-bit words.
// RULE7 - Cb and Cr alternate, sited on odd luma.
// RULE8 - Reserved extreme levels never carried as video.
// RULE9 - RGB carried as 30-bit words.
// RULE10 - Fixed line length, starts before sync reference.
// RULE11 - 2200 or 2750 luma samples per line.
// RULE12 - 1920 active luma, 960 active chroma samples.
// RULE13 - First active sample 192 periods after sync.
// RULE14 - Exactly 1080 active lines per picture.
// RULE15 - Chroma co-sited, orthogonal repeating sampling grid.
// RULE16 - Video within 1.00..254.75; timing uses extremes.
// RULE17 - 8-bit words get two zero LSBs appended.
// RULE18 - Start and end codes: three preamble, one flag word.
// RULE19 - Field and vblank flags change only at end code.
// RULE20 - Clamp codes falling into reserved ranges.
`ifndef HVF_DEFINES_SVH
`define HVF_DEFINES_SVH
`define HVF_D8 3'h1
`define HVF_D10 3'h4
`define HVF_Y_GAIN 10'hdb
`define HVF_Y_OFS 10'h010
`define HVF_C_GAIN 10'he0
`define HVF_C_OFS 10'h080
`define HVF_VID_MIN 10'h004
`define HVF_VID_MAX 10'h3fb
`define HVF_TRS_HI 10'h3ff
`define HVF_TRS_LO 10'h000
`define HVF_LINE_6030 12'h898
`define HVF_LINE_24 12'habe
`define HVF_ACTIVE 12'h780
`define HVF_SYNC_TO_ACT 12'h0c0
`define HVF_ACT_LINES 11'h438
`define HVF_TOTAL_LINES 11'h465
`define HVF_XY_EAV 10'h274
`define HVF_XY_SAV 10'h200
`endif

//--- core/hvf_pkg.sv
// Types for the HD video sample formatter.
// Assumes the constants header is compiled alongside.
package hvf_pkg;
	typedef enum logic [3:0] {
		HVF_ST_EAV = 4'h1,
		HVF_ST_BLANK = 4'h2,
		HVF_ST_SAV = 4'h4,
		HVF_ST_ACTIVE = 4'h8
	} hvf_state_t;
endpackage

//--- core/hvf_formatter.sv
// Formats normalized component samples into the 20-bit and 30-bit word streams.
// Assumes samples arrive on sys_clk and the link side has its own clock, link_clk.
`timescale 1ns/1ps
`include "hvf_defines.svh"
module hvf_formatter (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic mode_10bit,
	input wire logic mode_24hz,
	input wire logic [11:0] in_y,
	input wire logic [11:0] in_cb,
	input wire logic [11:0] in_cr,
	input wire logic [11:0] in_r,
	input wire logic [11:0] in_g,
	input wire logic [11:0] in_b,
	output logic [19:0] ycc_word,
	output logic [29:0] rgb_word,
	output logic line_start,
	output logic sync_ref,
	output logic active_video,
	output logic field_flag,
	output logic vblank_flag
);
	// Inputs are unsigned fractions of 4096 for luma/RGB and two's complement for chroma.
	// Quantization runs on sys_clk; a toggle handshake moves each settled sample set to the link.
	logic [9:0] q_y_ff;
	logic [9:0] q_cb_ff;
	logic [9:0] q_cr_ff;
	logic [9:0] q_r_ff;
	logic [9:0] q_g_ff;
	logic [9:0] q_b_ff;
	logic tgl_ff;
	logic [1:0] ack_sync_ff;
	logic load_q;
	logic [1:0] sync_mode_ff;
	logic [1:0] sync_24_ff;
	logic [2:0] tgl_sync_ff;
	logic load_lk;
	logic ten_ff;
	logic h24_ff;
	logic [9:0] lk_y_ff;
	logic [9:0] lk_cb_ff;
	logic [9:0] lk_cr_ff;
	logic [9:0] lk_r_ff;
	logic [9:0] lk_g_ff;
	logic [9:0] lk_b_ff;
	logic [11:0] hcnt_ff;
	logic [11:0] nxt_hcnt;
	logic line_wrap;
	logic [11:0] sav_point;
	logic [11:0] sync_point;
	logic [10:0] vcnt_ff;
	logic [10:0] nxt_vcnt;
	logic [1:0] wcnt_ff;
	logic [1:0] word_idx;
	hvf_pkg::hvf_state_t st_ff;
	hvf_pkg::hvf_state_t nxt_st;
	logic [11:0] line_len;
	logic [9:0] chroma_sel;

	// Scale, offset and round, then clamp out of the reserved levels.
	function automatic logic [9:0] quant(input logic [11:0] v, input logic chroma, input logic ten);
		logic [23:0] acc;
		logic [9:0] code;
		logic [2:0] d;
		acc = 24'h0;
		code = 10'h0;
		d = ten ? `HVF_D10 : `HVF_D8; // see RULE1
		if (chroma) begin
			// see RULE3
			acc = 24'(signed'(v) * signed'({1'b0, `HVF_C_GAIN}) * signed'({1'b0, d}))
				+ 24'({`HVF_C_OFS, 12'h000} * d) + 24'h800;
		end else begin
			// see RULE2
			acc = 24'(v * `HVF_Y_GAIN * d) + 24'({`HVF_Y_OFS, 12'h000} * d) + 24'h800;
		end
		code = acc[21:12];
		if (acc[23]) begin
			code = 10'h0;
		end
		// Ten-bit codes already fill all ten bits of the quarter-step scale; eight-bit get two zero LSBs.
		code = ten ? code : {code[7:0], 2'b00}; // see RULE17
		if (code < `HVF_VID_MIN) begin
			code = ten ? `HVF_VID_MIN : 10'h004; // see RULE8, RULE20
		end
		if (code > `HVF_VID_MAX) begin
			code = ten ? `HVF_VID_MAX : 10'h3f8; // see RULE16, RULE20
		end
		return code;
	endfunction

	// Fourth word of a timing code: fixed pattern with the picture flags in bits 8 and 7.
	function automatic logic [9:0] trs_xyz(input logic eav, input logic f, input logic v);
		logic [9:0] w;
		w = eav ? `HVF_XY_EAV : `HVF_XY_SAV;
		w[8] = f;
		w[7] = v;
		return w;
	endfunction

	// A sample set is taken only after the link has echoed the previous one, so the link never
	// copies a code while it changes. Sets arriving in between are dropped, a limit of this crossing.
	assign load_q = (tgl_ff == ack_sync_ff[1]);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_y_ff <= `HVF_Y_OFS;
			q_r_ff <= `HVF_Y_OFS;
			q_g_ff <= `HVF_Y_OFS;
			q_b_ff <= `HVF_Y_OFS;
		end else if (load_q) begin
			q_y_ff <= quant(in_y, 1'b0, ten_ff);
			q_r_ff <= quant(in_r, 1'b0, ten_ff);
			q_g_ff <= quant(in_g, 1'b0, ten_ff);
			q_b_ff <= quant(in_b, 1'b0, ten_ff);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_cb_ff <= `HVF_C_OFS;
			q_cr_ff <= `HVF_C_OFS;
		end else if (load_q) begin
			q_cb_ff <= quant(in_cb, 1'b1, ten_ff);
			q_cr_ff <= quant(in_cr, 1'b1, ten_ff);
		end
	end

	// Mode pins are asynchronous straps, so each domain sees its pin only through three flops.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_mode_ff <= 2'h0;
			ten_ff <= 1'b0;
		end else begin
			sync_mode_ff <= {sync_mode_ff[0], mode_10bit};
			ten_ff <= sync_mode_ff[1];
		end
	end

	// Request toggle: flips with each captured set, then waits for its echo.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_ff <= 1'b0;
		end else if (load_q) begin
			tgl_ff <= ~tgl_ff;
		end
	end

	// Echo from the link's last sync flop, brought back through two flops.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_sync_ff <= 2'h0;
		end else begin
			ack_sync_ff <= {ack_sync_ff[0], tgl_sync_ff[2]};
		end
	end

	// The link copies the held set once it sees the toggle settled.
	assign load_lk = (tgl_sync_ff[2] != tgl_sync_ff[1]);

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tgl_sync_ff <= 3'h0;
			sync_24_ff <= 2'h0;
			h24_ff <= 1'b0;
		end else begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], tgl_ff};
			sync_24_ff <= {sync_24_ff[0], mode_24hz};
			h24_ff <= sync_24_ff[1];
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lk_y_ff <= `HVF_Y_OFS;
			lk_r_ff <= `HVF_Y_OFS;
			lk_g_ff <= `HVF_Y_OFS;
			lk_b_ff <= `HVF_Y_OFS;
			lk_cb_ff <= `HVF_C_OFS;
			lk_cr_ff <= `HVF_C_OFS;
		end else if (load_lk) begin
			lk_y_ff <= q_y_ff;
			lk_r_ff <= q_r_ff;
			lk_g_ff <= q_g_ff;
			lk_b_ff <= q_b_ff;
			lk_cb_ff <= q_cb_ff;
			lk_cr_ff <= q_cr_ff;
		end
	end

	// One-way link: nothing is ever received from the destination. see RULE4
	assign line_len = h24_ff ? `HVF_LINE_24 : `HVF_LINE_6030; // see RULE10, RULE11
	// Count zero is the first word of the end code, which opens the digital line.
	assign nxt_hcnt = (hcnt_ff == line_len - 12'h001) ? 12'h000 : hcnt_ff + 12'h001;
	assign line_wrap = (nxt_hcnt == 12'h000);
	// The start code takes the four words just before the active line.
	assign sav_point = line_len - `HVF_ACTIVE - 12'h004;
	assign sync_point = line_len - `HVF_ACTIVE - `HVF_SYNC_TO_ACT; // see RULE13
	assign nxt_vcnt = (vcnt_ff == `HVF_TOTAL_LINES - 11'h001) ? 11'h000 : vcnt_ff + 11'h001;
	// Position of the next word inside a timing code; zero on entry to the code.
	assign word_idx = (nxt_st == st_ff) ? wcnt_ff + 2'h1 : 2'h0;
	// Active lines start on an even count, so even counts carry blue difference. see RULE7, RULE15
	assign chroma_sel = (nxt_hcnt[0] == line_len[0]) ? lk_cb_ff : lk_cr_ff;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			hvf_pkg::HVF_ST_EAV: begin
				if (wcnt_ff == 2'h3) begin
					nxt_st = hvf_pkg::HVF_ST_BLANK;
				end
			end
			hvf_pkg::HVF_ST_BLANK: begin
				if (nxt_hcnt == sav_point) begin
					nxt_st = hvf_pkg::HVF_ST_SAV;
				end
			end
			hvf_pkg::HVF_ST_SAV: begin
				if (wcnt_ff == 2'h3) begin
					nxt_st = hvf_pkg::HVF_ST_ACTIVE;
				end
			end
			hvf_pkg::HVF_ST_ACTIVE: begin
				if (line_wrap) begin
					nxt_st = hvf_pkg::HVF_ST_EAV;
				end
			end
			default: begin
				nxt_st = hvf_pkg::HVF_ST_EAV;
			end
		endcase
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			hcnt_ff <= 12'h000;
		end else begin
			hcnt_ff <= nxt_hcnt;
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			st_ff <= hvf_pkg::HVF_ST_EAV;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wcnt_ff <= 2'h0;
		end else begin
			wcnt_ff <= (nxt_st != st_ff) ? 2'h0 : wcnt_ff + 2'h1;
		end
	end

	// Line counter and picture flags advance only as the end code starts a line. see RULE19
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			vcnt_ff <= 11'h000;
			field_flag <= 1'b0;
			vblank_flag <= 1'b1;
		end else if (line_wrap) begin
			vcnt_ff <= nxt_vcnt;
			vblank_flag <= (nxt_vcnt >= `HVF_ACT_LINES); // see RULE14
			field_flag <= 1'b0;
		end
	end

	// Line pulses and the active level, all aligned with the words below.
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			line_start <= 1'b0;
			sync_ref <= 1'b0;
			active_video <= 1'b0;
		end else begin
			line_start <= line_wrap; // see RULE10
			sync_ref <= (nxt_hcnt == sync_point); // see RULE13
			active_video <= (nxt_st == hvf_pkg::HVF_ST_ACTIVE); // see RULE12
		end
	end

	// Luma/chroma words: timing codes on both halves, samples in the active region.
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ycc_word <= {`HVF_C_OFS, `HVF_Y_OFS};
		end else begin
			case (nxt_st)
				hvf_pkg::HVF_ST_EAV, hvf_pkg::HVF_ST_SAV: begin
					// see RULE18, RULE5
					case (word_idx)
						2'h0: begin
							ycc_word <= {`HVF_TRS_HI, `HVF_TRS_HI};
						end
						2'h1, 2'h2: begin
							ycc_word <= {`HVF_TRS_LO, `HVF_TRS_LO};
						end
						default: begin
							ycc_word <= {2{trs_xyz(nxt_st == hvf_pkg::HVF_ST_EAV, field_flag, vblank_flag)}};
						end
					endcase
				end
				hvf_pkg::HVF_ST_ACTIVE: begin
					// One chroma sample and one luma sample per word. see RULE6
					ycc_word <= {chroma_sel, lk_y_ff};
				end
				default: begin
					ycc_word <= {`HVF_C_OFS, `HVF_Y_OFS};
				end
			endcase
		end
	end

	// RGB words share the active window of the luma/chroma words and rest at HVF_Y_OFS (10'h010) on each component elsewhere.
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rgb_word <= {`HVF_Y_OFS, `HVF_Y_OFS, `HVF_Y_OFS};
		end else if (nxt_st == hvf_pkg::HVF_ST_ACTIVE) begin
			rgb_word <= {lk_g_ff, lk_b_ff, lk_r_ff}; // see RULE9
		end else begin
			rgb_word <= {`HVF_Y_OFS, `HVF_Y_OFS, `HVF_Y_OFS};
		end
	end
endmodule // hvf_formatter

//--- test/hvf_formatter_properties.sv
// Concurrent checks on the link side of the formatter.
// Assumes it is bound to hvf_formatter and that link_clk runs through the run.
`timescale 1ns/1ps
module hvf_formatter_chk (
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic [19:0] ycc_word,
	input wire logic [29:0] rgb_word,
	input wire logic line_start,
	input wire logic sync_ref,
	input wire logic active_video,
	input wire logic field_flag,
	input wire logic vblank_flag
);
	logic [11:0] lc_ff;
	logic [11:0] ac_ff;
	default clocking @(posedge link_clk); endclocking
	default disable iff (!link_rst_n);
	function automatic logic ok(input logic [9:0] c);
		return c >= 10'h004 && c <= 10'h3fb;
	endfunction
	// The line counter stays at zero until the first line start, so a partial line is never judged.
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lc_ff <= 12'h000;
			ac_ff <= 12'h000;
		end else begin
			lc_ff <= line_start ? 12'h001 : (lc_ff == 12'h000 ? 12'h000 : lc_ff + 12'h001);
			ac_ff <= active_video ? ac_ff + 12'h001 : 12'h000;
		end
	end
	a_eav_preamble: assert property (line_start |-> ycc_word == 20'hfffff ##1 ycc_word == 20'h00000
		##1 ycc_word == 20'h00000) else $error("end code preamble wrong");
	a_line_len: assert property (line_start && lc_ff != 12'h000 |-> lc_ff inside {12'h898, 12'habe})
		else $error("line length wrong");
	a_sync_to_act: assert property (sync_ref |-> ##191 !active_video ##1 active_video)
		else $error("active start not 192 words after sync");
	a_active_len: assert property ($fell(active_video) |-> ac_ff == 12'h780)
		else $error("active word count wrong");
	a_ycc_range: assert property (active_video |-> ok(ycc_word[9:0]) && ok(ycc_word[19:10]))
		else $error("reserved level in video word");
	a_rgb_range: assert property (active_video |-> ok(rgb_word[9:0]) && ok(rgb_word[19:10]) && ok(rgb_word[29:20]))
		else $error("reserved level in rgb word");
	a_sav_before: assert property ($rose(active_video) |-> $past(ycc_word, 4) == 20'hfffff && $past(ycc_word, 3) == 20'h0)
		else $error("start code missing before active");
	a_flags_line: assert property ($changed(vblank_flag) || $changed(field_flag) |-> line_start)
		else $error("flag changed away from line start");
	cover property (line_start);
	cover property ($fell(active_video));
	cover property (sync_ref);
endmodule // hvf_formatter_chk

//--- test/hvf_link_sink.sv
// Destination model: watches the one-way word stream and records line figures.
// Assumes words change on link_clk and that the source alone drives the link.
`timescale 1ns/1ps
module hvf_link_sink (
	input wire logic link_clk,
	input wire logic [19:0] ycc_word,
	input wire logic [29:0] rgb_word,
	input wire logic line_start,
	input wire logic active_video,
	output logic [11:0] len_ff,
	output logic [11:0] alen_ff,
	output logic [19:0] w0_ff,
	output logic [19:0] w1_ff,
	output logic [29:0] rgb0_ff
);
	logic [11:0] cnt_ff;
	logic [11:0] acnt_ff;
	// Link ports are inputs only, since the destination never talks back.
	always_ff @(posedge link_clk) begin
		cnt_ff <= line_start ? 12'h001 : cnt_ff + 12'h001;
		if (line_start) len_ff <= cnt_ff;
		acnt_ff <= active_video ? acnt_ff + 12'h001 : 12'h000;
		if (!active_video && acnt_ff != 12'h000) alen_ff <= acnt_ff;
		if (active_video && acnt_ff == 12'h000) w0_ff <= ycc_word;
		if (active_video && acnt_ff == 12'h000) rgb0_ff <= rgb_word;
		if (active_video && acnt_ff == 12'h001) w1_ff <= ycc_word;
	end
endmodule // hvf_link_sink

//--- test/tb_hvf_formatter.sv
// Self-checking bench for the formatter: coding, chroma pairing and line geometry.
// Assumes the sink model and the checker are compiled before this file.
`timescale 1ns/1ps
module tb_hvf_formatter;
	logic sys_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, link_rst_n = 1'b0;
	logic mode_10bit = 1'b1, mode_24hz = 1'b0;
	logic [11:0] in_y = 12'h800, in_cb = 12'h800, in_cr = 12'h7ff, in_r = 12'h000, in_g = 12'hfff, in_b = 12'h800;
	logic [19:0] ycc_word, w0, w1;
	logic [29:0] rgb_word, rgb0;
	logic line_start, sync_ref, active_video, field_flag, vblank_flag;
	logic [11:0] len, alen;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	// The link clock starts off phase with the sample clock, since the two share no source.
	initial begin
		#7.3;
		forever #15 link_clk = ~link_clk;
	end
	hvf_formatter u_hvf_formatter (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n),
		.mode_10bit(mode_10bit), .mode_24hz(mode_24hz), .in_y(in_y), .in_cb(in_cb), .in_cr(in_cr), .in_r(in_r),
		.in_g(in_g), .in_b(in_b), .ycc_word(ycc_word), .rgb_word(rgb_word), .line_start(line_start),
		.sync_ref(sync_ref), .active_video(active_video), .field_flag(field_flag), .vblank_flag(vblank_flag));
	hvf_link_sink u_hvf_link_sink (.link_clk(link_clk), .ycc_word(ycc_word), .rgb_word(rgb_word),
		.line_start(line_start), .active_video(active_video), .len_ff(len), .alen_ff(alen), .w0_ff(w0),
		.w1_ff(w1), .rgb0_ff(rgb0));
	task automatic check(input logic [29:0] got, input logic [29:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_start();
		int n;
		n = 0;
		do begin
			@(posedge link_clk);
			#1;
			n++;
		end while (line_start !== 1'b1 && n < 3000);
		if (n >= 3000) err_count++;
	endtask
	// Both scenarios feed half-scale luma and blue, so the luma and blue codes show the depth factor.
	task automatic check_line(input logic [9:0] y, input logic [11:0] l);
		// The sink takes the line figures one edge after the line start.
		@(posedge link_clk);
		#1;
		check({28'h0000000, field_flag, vblank_flag}, 30'h00000000);
		check({10'h000, w0}, {10'h000, 10'h040, y});
		check({10'h000, w1}, {10'h000, 10'h3c0, y});
		check(rgb0, {10'h3ac, y, 10'h040});
		check({18'h00000, len}, {18'h00000, l});
		check({18'h00000, alen}, {18'h00000, 12'h780});
	endtask
	task automatic t_codes10();
		wait_start();
		wait_start();
		check_line(10'h1f6, 12'h898);
	endtask
	task automatic t_codes8_24();
		@(posedge sys_clk);
		#1;
		mode_10bit = 1'b0;
		mode_24hz = 1'b1;
		wait_start();
		wait_start();
		check_line(10'h1f8, 12'habe);
	endtask
	task automatic print_verdict();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge link_clk);
		#1 link_rst_n = 1'b1;
		t_codes10();
		t_codes8_24();
		print_verdict();
	end
	// The ceiling leaves room for five full lines of the longer length.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			print_verdict();
		end
	end
endmodule // tb_hvf_formatter
bind hvf_formatter hvf_formatter_chk u_hvf_formatter_chk (.link_clk(link_clk), .link_rst_n(link_rst_n),
	.ycc_word(ycc_word), .rgb_word(rgb_word), .line_start(line_start), .sync_ref(sync_ref),
	.active_video(active_video), .field_flag(field_flag), .vblank_flag(vblank_flag));
